// ===== design/qsp_pkg.sv
// Purpose: Shared constants, carriers and helpers of the burst SRAM port logic
// Assumes: 36-bit word configuration; other widths follow from the word width
// Notes:   All numbers used by more than one file live here

package qsp_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int DW = 36;
   // Lane masks: two nibbles for 8 bits, else one per 9-bit byte
   localparam int MW = (DW == 8) ? 2 : ((DW == 36) ? 4 : ((DW == 18) ? 2 : 1));
   localparam int LW = DW / MW;
   // Address depth per configuration
   localparam int AW = (DW <= 9) ? 20 : ((DW == 18) ? 19 : 18);

   // ----------------------------------------------------------------
   // Crossing and output constants
   // ----------------------------------------------------------------
   localparam int         SYNC_STAGES = 2;
   localparam logic       ECHO_RISE   = 1'h1;
   localparam logic       ECHO_FALL   = 1'h0;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [DW-1:0] w0;
      logic [DW-1:0] w1;
   } qsp_pair_t;

   typedef struct packed {
      logic [AW-1:0] addr;
      qsp_pair_t     data;
      qsp_pair_t     en;
   } qsp_wreq_t;

   // Inputs taken on the falling edge of the link clock
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
      logic [MW-1:0] mask_n;
   } qsp_fall_t;

   typedef enum logic [1:0] {
      QSP_OST_IDLE   = 2'h1,
      QSP_OST_SECOND = 2'h2
   } qsp_ost_t;

   // ----------------------------------------------------------------
   // Lane mask to bit enables
   // ----------------------------------------------------------------
   function automatic logic [DW-1:0] qsp_lane_en(input logic [MW-1:0] mask_n);
      logic [DW-1:0] en;
      en = '0;
      for (int i = 0; i < MW; i++) begin
         en[i*LW +: LW] = {LW{~mask_n[i]}};
      end
      return en;
   endfunction : qsp_lane_en

endpackage : qsp_pkg

// ===== design/qsp_sync.sv
// Purpose: Two-stage synchroniser for a bundle of independent levels
// Assumes: Each bit is a level or a toggle; no multi-bit value is relied on
// Notes:   First stage is read only by the second

`timescale 1ns/1ps

module qsp_sync #(
   parameter int W = 1
) (
   // Destination clock
   input  wire logic         clk_in,
   // Levels
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [qsp_pkg::SYNC_STAGES-1:0][W-1:0] stage_q;

   always_ff @(posedge clk_in) begin
      stage_q <= {stage_q[0], d_in};
   end

   assign q_out = stage_q[qsp_pkg::SYNC_STAGES-1];

endmodule : qsp_sync

// ===== design/qsp_kfall.sv
// Purpose: Capture register for inputs presented on the negative link clock edge
// Assumes: Negative input clock is the complement of the positive one
// Notes:   Held for a full cycle so the next positive edge can use it

`timescale 1ns/1ps

module qsp_kfall (
   // Link clock
   input  wire logic              k_clk_in,
   // Sample
   input  wire qsp_pkg::qsp_fall_t cap_in,
   output qsp_pkg::qsp_fall_t      cap_out
);

   qsp_pkg::qsp_fall_t cap_q;

   // Rising edge of the negative clock
   always_ff @(negedge k_clk_in) begin
      cap_q <= cap_in;
   end

   assign cap_out = cap_q;

endmodule : qsp_kfall

// ===== design/qsp_port.sv
// Purpose: Device-side logic of a separate-port two-word burst SRAM pin interface
// Assumes: Array sits on the system clock; pins run on the link and output clocks
// Notes:   Read data leaves as a rise/fall pair for an outside DDR output cell
//
// How it works
// - Write data taken on positive and negative link clock edges.
// - Low write select at positive edge starts a write, high ignores data.
// - In 8-bit form two nibble masks gate bits 3:0 and 7:4.
// - Byte masks per word choose written bytes; others stay unchanged.
// - Read address on positive edge, write address on negative edge.
// - Address width 20, 19 or 18 bits; each location holds two words.
// - Address on an edge ignored when its port is deselected.
// - Read data launched on output clock edges, or link clock in single mode.
// - Read outputs float whenever the output stage is idle with no new read data.
// - Read select sampled on positive edge; pending read finishes, then float.
// - Every read returns two consecutive words of one location.
// - All accesses begin only on the positive link clock edge.
// - Negative clock captures write address and second word with masks.
// - With the PLL disabled, read data uses one-cycle latency timing.
// - Echo clocks run free, locked to the output clock.

`timescale 1ns/1ps

module qsp_port (
   // System clock and reset
   input  wire logic                   clk_sys_in,
   input  wire logic                   nrst_in,
   // Link: positive input clock and synchronous pins
   input  wire logic                   k_clk_in,
   input  wire logic [qsp_pkg::AW-1:0] addr_in,
   input  wire logic                   read_port_sel_n_in,
   input  wire logic                   write_port_sel_n_in,
   input  wire logic [qsp_pkg::DW-1:0] d_in,
   input  wire logic [qsp_pkg::MW-1:0] byte_mask_n_in,
   // Output clock (C, or K in single clock mode) and read pins
   input  wire logic                   q_clk_in,
   input  wire logic                   pll_disable_n_in,
   output logic      [qsp_pkg::DW-1:0] q_rise_out,
   output logic      [qsp_pkg::DW-1:0] q_fall_out,
   output logic                        q_oe_out,
   output logic                        echo_clk_rise_out,
   output logic                        echo_clk_fall_out,
   // Array port on the system clock
   output logic                        core_rd_out,
   output logic                        core_wr_out,
   output logic      [qsp_pkg::AW-1:0] core_addr_out,
   output qsp_pkg::qsp_pair_t          core_wdata_out,
   output qsp_pkg::qsp_pair_t          core_wen_out,
   input  wire qsp_pkg::qsp_pair_t     core_rdata_in
);

   // ----------------------------------------------------------------
   // State carriers, one per clock domain
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                   rd_tgl;
      logic                   wr_tgl;
      logic                   wr_arm;
      logic [qsp_pkg::AW-1:0] rd_addr;
      qsp_pkg::qsp_wreq_t     wreq;
   } qsp_kst_t;

   typedef struct packed {
      logic                   rd_seen;
      logic                   wr_seen;
      logic                   rd_wait;
      logic                   core_rd;
      logic                   core_wr;
      logic                   data_tgl;
      logic [qsp_pkg::AW-1:0] addr;
      qsp_pkg::qsp_pair_t     wdata;
      qsp_pkg::qsp_pair_t     wen;
      qsp_pkg::qsp_pair_t     rdata;
   } qsp_sst_t;

   typedef struct packed {
      qsp_pkg::qsp_ost_t      st;
      logic                   seen;
      logic [qsp_pkg::DW-1:0] hold;
      logic [qsp_pkg::DW-1:0] rise;
      logic [qsp_pkg::DW-1:0] fall;
      logic                   oe;
      logic                   echo_r;
      logic                   echo_f;
   } qsp_ost_st_t;

   qsp_kst_t           k_q, k_d;
   qsp_sst_t           s_q, s_d;
   qsp_ost_st_t        o_q, o_d;
   qsp_pkg::qsp_fall_t fall_cap;
   logic [2:0]         k_sync;
   logic [1:0]         s_sync;
   logic [2:0]         o_sync;
   logic               k_nrst;
   logic               busy_rd;
   logic               busy_wr;
   logic               o_nrst;
   logic               o_new;
   logic               pll_off;

   // ----------------------------------------------------------------
   // Crossings
   // ----------------------------------------------------------------
   // Reset and both acknowledges into the link domain
   qsp_sync #(.W(3)) u_k_sync (
      .clk_in (k_clk_in),
      .d_in   ({nrst_in, o_q.seen, s_q.wr_seen}),
      .q_out  (k_sync)
   );

   // Request toggles into the system domain
   qsp_sync #(.W(2)) u_s_sync (
      .clk_in (clk_sys_in),
      .d_in   ({k_q.rd_tgl, k_q.wr_tgl}),
      .q_out  (s_sync)
   );

   // Reset, data toggle and PLL strap into the output domain
   qsp_sync #(.W(3)) u_o_sync (
      .clk_in (q_clk_in),
      .d_in   ({nrst_in, s_q.data_tgl, pll_disable_n_in}),
      .q_out  (o_sync)
   );

   qsp_kfall u_kfall (
      .k_clk_in (k_clk_in),
      .cap_in   (qsp_pkg::qsp_fall_t'{addr: addr_in, data: d_in, mask_n: byte_mask_n_in}),
      .cap_out  (fall_cap)
   );

   // ----------------------------------------------------------------
   // Link domain: command capture
   // ----------------------------------------------------------------
   // One request in flight per port; a select arriving while busy is dropped
   assign k_nrst  = k_sync[2];
   assign busy_rd = k_q.rd_tgl != k_sync[1];
   assign busy_wr = k_q.wr_tgl != k_sync[0];

   always_comb begin
      k_d = k_q;
      // Read select and address taken only on the positive edge
      if (!read_port_sel_n_in && !busy_rd) begin
         k_d.rd_addr = addr_in;
         k_d.rd_tgl  = ~k_q.rd_tgl;
      end
      // Second half arrives on the negative edge after the select
      k_d.wr_arm = 1'b0;
      if (k_q.wr_arm) begin
         k_d.wreq.addr    = fall_cap.addr;
         k_d.wreq.data.w1 = fall_cap.data;
         k_d.wreq.en.w1   = qsp_pkg::qsp_lane_en(fall_cap.mask_n);
         k_d.wr_tgl       = ~k_q.wr_tgl;
      end
      // A high write select leaves data and address untouched
      if (!write_port_sel_n_in && !busy_wr && !k_q.wr_arm) begin
         k_d.wr_arm       = 1'b1;
         k_d.wreq.data.w0 = d_in;
         k_d.wreq.en.w0   = qsp_pkg::qsp_lane_en(byte_mask_n_in);
      end
      if (!k_nrst) begin
         k_d = '0;
      end
   end

   always_ff @(posedge k_clk_in) begin
      k_q <= k_d;
   end

   // ----------------------------------------------------------------
   // System domain: array access
   // ----------------------------------------------------------------
   // Writes win a tie; a read waits one cycle and loses nothing
   always_comb begin
      s_d         = s_q;
      s_d.core_rd = 1'b0;
      s_d.core_wr = 1'b0;
      s_d.rd_wait = s_q.core_rd;
      if (s_q.rd_wait) begin
         s_d.rdata    = core_rdata_in;
         s_d.data_tgl = ~s_q.data_tgl;
      end
      if (s_sync[0] != s_q.wr_seen) begin
         s_d.wr_seen = ~s_q.wr_seen;
         s_d.core_wr = 1'b1;
         s_d.addr    = k_q.wreq.addr;
         s_d.wdata   = k_q.wreq.data;
         s_d.wen     = k_q.wreq.en;
      end else if (s_sync[1] != s_q.rd_seen && !s_q.core_rd && !s_q.rd_wait) begin
         s_d.rd_seen = ~s_q.rd_seen;
         s_d.core_rd = 1'b1;
         s_d.addr    = k_q.rd_addr;
      end
      if (!nrst_in) begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      s_q <= s_d;
   end

   assign core_rd_out    = s_q.core_rd;
   assign core_wr_out    = s_q.core_wr;
   assign core_addr_out  = s_q.addr;
   assign core_wdata_out = s_q.wdata;
   assign core_wen_out   = s_q.wen;

   // ----------------------------------------------------------------
   // Output domain: read burst
   // ----------------------------------------------------------------
   assign o_nrst  = o_sync[2];
   assign o_new   = o_sync[1] != o_q.seen;
   assign pll_off = !o_sync[0];

   always_comb begin
      o_d        = o_q;
      o_d.echo_r = qsp_pkg::ECHO_RISE;
      o_d.echo_f = qsp_pkg::ECHO_FALL;
      unique case (o_q.st)
         qsp_pkg::QSP_OST_IDLE: begin
            o_d.oe = 1'b0;
            if (o_new) begin
               o_d.seen = ~o_q.seen;
               o_d.oe   = 1'b1;
               if (pll_off) begin
                  // Whole burst inside one output cycle
                  o_d.rise = s_q.rdata.w0;
                  o_d.fall = s_q.rdata.w1;
               end else begin
                  // Half-cycle later launch; second word on next rise
                  o_d.fall = s_q.rdata.w0;
                  o_d.hold = s_q.rdata.w1;
                  o_d.st   = qsp_pkg::QSP_OST_SECOND;
               end
            end
         end
         qsp_pkg::QSP_OST_SECOND: begin
            o_d.rise = o_q.hold;
            o_d.oe   = 1'b1;
            o_d.st   = qsp_pkg::QSP_OST_IDLE;
         end
         default: begin
            o_d.st = qsp_pkg::QSP_OST_IDLE;
            o_d.oe = 1'b0;
         end
      endcase
      if (!o_nrst) begin
         o_d    = '0;
         o_d.st = qsp_pkg::QSP_OST_IDLE;
      end
   end

   always_ff @(posedge q_clk_in) begin
      o_q <= o_d;
   end

   assign q_rise_out        = o_q.rise;
   assign q_fall_out        = o_q.fall;
   assign q_oe_out          = o_q.oe;
   assign echo_clk_rise_out = o_q.echo_r;
   assign echo_clk_fall_out = o_q.echo_f;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_rd_take;
      @(posedge k_clk_in) disable iff (!k_nrst)
      (!read_port_sel_n_in && !busy_rd) |=>
         (k_q.rd_tgl != $past(k_q.rd_tgl)) && (k_q.rd_addr == $past(addr_in));
   endproperty
   a_rd_take: assert property (p_rd_take)
      else $error("read address not taken on selected edge");

   property p_rd_ignore;
      @(posedge k_clk_in) disable iff (!k_nrst)
      read_port_sel_n_in |=> $stable(k_q.rd_tgl) && $stable(k_q.rd_addr);
   endproperty
   a_rd_ignore: assert property (p_rd_ignore)
      else $error("deselected read port changed state");

   property p_wr_ignore;
      @(posedge k_clk_in) disable iff (!k_nrst)
      (write_port_sel_n_in && !k_q.wr_arm) |=> !k_q.wr_arm && $stable(k_q.wr_tgl);
   endproperty
   a_wr_ignore: assert property (p_wr_ignore)
      else $error("deselected write port started a write");

   property p_wr_pair;
      @(posedge k_clk_in) disable iff (!k_nrst)
      (!write_port_sel_n_in && !busy_wr && !k_q.wr_arm) |=>
         (k_q.wreq.data.w0 == $past(d_in)) ##1
         (k_q.wr_tgl != $past(k_q.wr_tgl)) && (k_q.wreq.data.w1 == $past(fall_cap.data))
         && (k_q.wreq.addr == $past(fall_cap.addr));
   endproperty
   a_wr_pair: assert property (p_wr_pair)
      else $error("write burst not assembled from both edges");

   property p_wr_mask;
      @(posedge k_clk_in) disable iff (!k_nrst)
      k_q.wr_arm |=> (k_q.wreq.en.w1 == qsp_pkg::qsp_lane_en($past(fall_cap.mask_n)));
   endproperty
   a_wr_mask: assert property (p_wr_mask)
      else $error("second word lane enables do not follow masks");

   property p_core_rd;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      s_q.core_rd |=> ##1 (s_q.rdata == $past(core_rdata_in))
         && (s_q.data_tgl != $past(s_q.data_tgl));
   endproperty
   a_core_rd: assert property (p_core_rd)
      else $error("array read pair not captured");

   property p_burst_off;
      @(posedge q_clk_in) disable iff (!o_nrst)
      (o_q.st == qsp_pkg::QSP_OST_IDLE && o_new && pll_off) |=>
         q_oe_out && (q_rise_out == $past(s_q.rdata.w0)) && (q_fall_out == $past(s_q.rdata.w1));
   endproperty
   a_burst_off: assert property (p_burst_off)
      else $error("single-cycle burst misplaced");

   property p_burst_on;
      @(posedge q_clk_in) disable iff (!o_nrst)
      (o_q.st == qsp_pkg::QSP_OST_IDLE && o_new && !pll_off) |=>
         (q_oe_out && q_fall_out == $past(s_q.rdata.w0)) ##1
         (q_oe_out && q_rise_out == $past(s_q.rdata.w1, 2));
   endproperty
   a_burst_on: assert property (p_burst_on)
      else $error("split burst misplaced");

   property p_float;
      @(posedge q_clk_in) disable iff (!o_nrst)
      (o_q.st == qsp_pkg::QSP_OST_IDLE && !o_new) |=> !q_oe_out;
   endproperty
   a_float: assert property (p_float)
      else $error("read outputs driven while idle");

   property p_echo;
      @(posedge q_clk_in) disable iff (!o_nrst)
      o_nrst |=> echo_clk_rise_out && !echo_clk_fall_out;
   endproperty
   a_echo: assert property (p_echo)
      else $error("echo clock pattern stopped");

endmodule : qsp_port

// ===== dv/qsp_host.sv
// Purpose: Host controller model driving the link pins of the burst SRAM port
// Assumes: Single clock mode; K runs free so the device PLL can stay locked
// Notes:   Released pins show the inverse of their last value, never a kind hold

`timescale 1ns/1ps

module qsp_host (
   // Link clock
   input  wire logic                   k_clk_in,
   // Link pins
   output logic      [qsp_pkg::AW-1:0] addr_out,
   output logic                        read_port_sel_n_out,
   output logic                        write_port_sel_n_out,
   output logic      [qsp_pkg::DW-1:0] d_out,
   output logic      [qsp_pkg::MW-1:0] byte_mask_n_out
);
   initial begin
      addr_out             = '0;
      read_port_sel_n_out  = 1'h1;
      write_port_sel_n_out = 1'h1;
      d_out                = '0;
      byte_mask_n_out      = '1;
   end

   // ----------------------------------------------------------------
   // Transfers
   // ----------------------------------------------------------------
   // First word with the select on a positive edge, second word and address on the negative edge after it
   task automatic write_burst(input logic [qsp_pkg::AW-1:0] a, input qsp_pkg::qsp_pair_t w,
                              input logic [qsp_pkg::MW-1:0] m0,
                              input logic [qsp_pkg::MW-1:0] m1);
      @(posedge k_clk_in);
      #1;
      write_port_sel_n_out = 1'h0;
      d_out                = w.w0;
      byte_mask_n_out      = m0;
      @(posedge k_clk_in);
      #1;
      write_port_sel_n_out = 1'h1;
      addr_out             = a;
      d_out                = w.w1;
      byte_mask_n_out      = m1;
      @(negedge k_clk_in);
      #1;
      addr_out        = ~a;
      d_out           = ~w.w1;
      byte_mask_n_out = ~m1;
   endtask : write_burst

   task automatic read_req(input logic [qsp_pkg::AW-1:0] a);
      @(posedge k_clk_in);
      #1;
      read_port_sel_n_out = 1'h0;
      addr_out            = a;
      @(posedge k_clk_in);
      #1;
      read_port_sel_n_out = 1'h1;
      addr_out            = ~a;
   endtask : read_req

   // Busy pins with both ports deselected
   task automatic idle_noise(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge k_clk_in);
         #1;
         addr_out        = ~addr_out;
         d_out           = ~d_out;
         byte_mask_n_out = byte_mask_n_out + 4'h1;
      end
   endtask : idle_noise

endmodule : qsp_host

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the burst SRAM port with host and array models
// Assumes: Single clock mode, output clock taken from K
// Notes:   Array model answers one system cycle after each read strobe

`timescale 1ns/1ps

module tb_top;
   localparam logic [qsp_pkg::AW-1:0] ADDR_A = 18'h2a5c1;
   localparam logic [qsp_pkg::AW-1:0] ADDR_B = 18'h15a3e;
   localparam qsp_pkg::qsp_pair_t     DATA_A = {36'h912345678, 36'h6edcba987};
   localparam qsp_pkg::qsp_pair_t     DATA_B = {36'h0f0f0f0f0, 36'hf0f0f0f0f};

   logic                   clk_sys_in;
   logic                   k_raw;
   logic                   k_clk;
   logic                   nrst_in;
   logic                   pll_disable_n_in;
   logic [qsp_pkg::AW-1:0] addr;
   logic                   rd_sel_n;
   logic                   wr_sel_n;
   logic [qsp_pkg::DW-1:0] d;
   logic [qsp_pkg::MW-1:0] mask_n;
   logic [qsp_pkg::DW-1:0] q_rise;
   logic [qsp_pkg::DW-1:0] q_fall;
   logic                   q_oe;
   logic                   echo_r;
   logic                   echo_f;
   logic                   core_rd;
   logic                   core_wr;
   logic [qsp_pkg::AW-1:0] core_addr;
   qsp_pkg::qsp_pair_t     core_wdata;
   qsp_pkg::qsp_pair_t     core_wen;
   qsp_pkg::qsp_pair_t     core_rdata;
   qsp_pkg::qsp_pair_t     mem [logic [qsp_pkg::AW-1:0]];
   int                     wr_count;
   int                     oe_count;
   int                     bad_count;
   int                     tests_run;

   always #5 clk_sys_in = ~clk_sys_in;
   always #3 k_raw = ~k_raw;
   // Offset keeps K edges clear of system clock edges
   assign #0.7 k_clk = k_raw;

   qsp_host host (.k_clk_in(k_clk), .addr_out(addr), .read_port_sel_n_out(rd_sel_n),
                  .write_port_sel_n_out(wr_sel_n), .d_out(d), .byte_mask_n_out(mask_n));

   // Output clock is K itself
   qsp_port dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .k_clk_in(k_clk),
                 .addr_in(addr), .read_port_sel_n_in(rd_sel_n), .write_port_sel_n_in(wr_sel_n),
                 .d_in(d), .byte_mask_n_in(mask_n), .q_clk_in(k_clk),
                 .pll_disable_n_in(pll_disable_n_in), .q_rise_out(q_rise), .q_fall_out(q_fall),
                 .q_oe_out(q_oe), .echo_clk_rise_out(echo_r), .echo_clk_fall_out(echo_f),
                 .core_rd_out(core_rd), .core_wr_out(core_wr), .core_addr_out(core_addr),
                 .core_wdata_out(core_wdata), .core_wen_out(core_wen),
                 .core_rdata_in(core_rdata));

   // ----------------------------------------------------------------
   // Array model
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in) begin : array_model
      qsp_pkg::qsp_pair_t old;
      old = '0;
      if (core_wr === 1'h1) begin
         if (mem.exists(core_addr)) old = mem[core_addr];
         mem[core_addr] = (old & ~core_wen) | (core_wdata & core_wen);
         wr_count++;
      end
      // Pair valid for one cycle only, scrambled otherwise
      core_rdata <= (core_rd === 1'h1) ? mem[core_addr] : ~core_rdata;
   end

   always @(posedge k_clk) if (q_oe === 1'h1) oe_count++;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk_val(input string name, input logic [71:0] exp, input logic [71:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_val

   task automatic finish_test();
      if (bad_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   function automatic logic [qsp_pkg::DW-1:0] lanes(input logic [qsp_pkg::MW-1:0] m);
      for (int i = 0; i < qsp_pkg::DW; i++) lanes[i] = ~m[i / qsp_pkg::LW];
   endfunction : lanes

   task automatic wait_for(input bit on_k);
      for (int i = 0; i < 60; i++) begin
         if (on_k) @(negedge k_clk);
         else @(negedge clk_sys_in);
         if ((on_k ? q_oe : core_wr) === 1'h1) return;
      end
      bad_count++;
      $display("ERROR %s expected 1 seen timeout", on_k ? "q_oe" : "core_wr");
      finish_test();
   endtask : wait_for

   task automatic do_write(input logic [qsp_pkg::AW-1:0] a, input qsp_pkg::qsp_pair_t w,
                           input logic [qsp_pkg::MW-1:0] m0, input logic [qsp_pkg::MW-1:0] m1);
      qsp_pkg::qsp_pair_t en;
      en = {lanes(m0), lanes(m1)};
      host.write_burst(a, w, m0, m1);
      wait_for(1'b0);
      chk_val("core_addr", a, core_addr);
      chk_val("core_wen", en, core_wen);
      chk_val("core_wdata", w & en, core_wdata & core_wen);
      // Array acknowledge needs two K edges to clear the busy write port
      repeat (4) @(negedge k_clk);
   endtask : do_write

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic sc_reset();
      repeat (7) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk_val("q_oe in reset", 0, q_oe);
      chk_val("core_wr in reset", 0, core_wr);
      @(posedge clk_sys_in);
      #1;
      nrst_in = 1'h1;
      repeat (10) @(negedge k_clk);
      chk_val("echo pair", 2'h2, {echo_r, echo_f});
   endtask : sc_reset

   task automatic sc_write_full();
      do_write(ADDR_A, DATA_A, 4'h0, 4'h0);
      do_write(ADDR_B, DATA_A, 4'h0, 4'h0);
   endtask : sc_write_full

   task automatic sc_write_masked();
      do_write(ADDR_B, DATA_B, 4'h5, 4'ha);
   endtask : sc_write_masked

   task automatic sc_deselect();
      int n;
      int o;
      repeat (10) @(negedge clk_sys_in);
      n = wr_count;
      o = oe_count;
      host.idle_noise(16);
      repeat (20) @(negedge clk_sys_in);
      chk_val("writes while deselected", n, wr_count);
      chk_val("q_oe while deselected", o, oe_count);
   endtask : sc_deselect

   task automatic sc_read_pll_on();
      host.read_req(ADDR_A);
      wait_for(1'b1);
      chk_val("first word", DATA_A.w0, q_fall);
      @(negedge k_clk);
      chk_val("q_oe second half", 1, q_oe);
      chk_val("second word", DATA_A.w1, q_rise);
      @(negedge k_clk);
      chk_val("q_oe after burst", 0, q_oe);
   endtask : sc_read_pll_on

   task automatic sc_read_pll_off();
      qsp_pkg::qsp_pair_t en;
      qsp_pkg::qsp_pair_t exp;
      en  = {lanes(4'h5), lanes(4'ha)};
      exp = (DATA_A & ~en) | (DATA_B & en);
      @(posedge clk_sys_in);
      #1;
      pll_disable_n_in = 1'h0;
      repeat (10) @(negedge k_clk);
      host.read_req(ADDR_B);
      wait_for(1'b1);
      chk_val("merged word0", exp.w0, q_rise);
      chk_val("merged word1", exp.w1, q_fall);
      @(negedge k_clk);
      chk_val("q_oe after short burst", 0, q_oe);
   endtask : sc_read_pll_off

   initial begin
      clk_sys_in       = 1'h0;
      k_raw            = 1'h0;
      nrst_in          = 1'h0;
      pll_disable_n_in = 1'h1;
      core_rdata       = '0;
      wr_count         = 0;
      oe_count         = 0;
      bad_count        = 0;
      tests_run        = 0;
      sc_reset();
      sc_write_full();
      sc_write_masked();
      sc_deselect();
      sc_read_pll_on();
      sc_read_pll_off();
      finish_test();
   end

endmodule : tb_top
